// [rtl/bmsc_burst_ctrl.v]
`timescale 1ns/1ps
`include "bmsc_regs.vh"
// Operation
// - Replica below low threshold outside a packet enters burst, halts switching.
// - Burst-off drives a power-down request for internal functions.
// - In burst-off, replica above high threshold restarts switching.
// - Burst-on effort is max(replica, low threshold) scaled by soft step.
// - First burst-on after entry has no soft-on ramp.
// - Packet keeps switching until 40 pulses, regardless of replica.
// - Last 7 cycles soft-off from step 7 down; burst-off after step 1.
// - Steps 1..7 scale by 1/3, 9/21 .. 19/21.
// - Soft-on runs step 1 up to step 7.
// - Replica above low during soft-off turns to soft-on at same step.
// - Later burst-on intervals ramp soft-on over 7 cycles.
// - Replica rising above high during soft-on cancels the ramp at once.
// - Last pulse of burst-on ends when sense node equals common mode.
// - Pin programming runs five ordered phases.
// - Initial phase holds pin at 5V, stores mirrored voltage as start value.
// - Soft start after boot charging; ends when replica below soft-start.
// - Low settling holds high threshold at 0.6 V, low from ratio.
// - Final phase holds pin 3.5 V; high from sunk current, low tracks.
// - Initial phase sources 54 uA from winding pin, reads ratio option.
// - Options map 0.95, 1, 0.9, 0.8, 0.6, minimal, 1 disabled.
// - Option 7 never enters burst, still clamps effort to low threshold.
// - Boot charging drives stored initial voltage onto soft-start pin.
module bmsc_burst_ctrl #(
   parameter W = 12
) (
   // Clock and reset
   input  wire         core_clk,
   input  wire         rst_b,
   // System state requests, same clock domain
   input  wire         prog_start,
   input  wire         boot_charging,
   input  wire         run_enable,
   // Async comparator inputs
   input  wire         cycle_done_pin,
   input  wire         sense_at_common_pin,
   // Analog measurement words, async
   input  wire [W-1:0] feedback_replica,
   input  wire [W-1:0] init_mirror_level,
   input  wire [W-1:0] sunk_mirror_level,
   input  wire [W-1:0] softstart_level,
   input  wire [2:0]   ratio_option,
   // Converter outputs
   output wire         switching_en,
   output wire         last_pulse_end,
   output wire [W-1:0] control_effort,
   output reg          burst_mode,
   output wire         power_down_req,
   // Threshold and pin outputs
   output reg  [W-1:0] burst_low_threshold,
   output reg  [W-1:0] burst_high_threshold,
   output reg  [W-1:0] softstart_initial,
   output reg  [12:0]  pin_hold_mv,
   output reg  [12:0]  pin_bias_na,
   output reg  [15:0]  winding_source_na,
   output reg          pin_drive_initial,
   output reg          softstart_charge,
   output reg  [2:0]   prog_phase,
   output reg          burst_disabled
);
   // Burst states
   localparam ST_RUN  = 2'd0;
   localparam ST_OFF  = 2'd1;
   localparam ST_ON   = 2'd2;
   localparam [12:0] SETTLE_MV = `BMSC_HIGH_SETTLE_MV;

   reg [1:0]   st_r;
   reg [1:0]   st_nxt;
   reg [5:0]   pulse_r;
   reg [2:0]   step_r;
   reg         soft_off_r;
   reg         soft_on_r;
   reg         first_on_r;
   reg         above_high_q_r;
   reg [2:0]   sync1_r;
   reg [2:0]   sync2_r;
   reg         cyc_q_r;
   reg [W-1:0] fb1_r;
   reg [W-1:0] fb_r;
   reg [W-1:0] ss1_r;
   reg [W-1:0] ss_r;
   reg [2*W+2:0] aw1_r;
   reg [2*W+2:0] aw_r;
   reg [10:0]  ratio_r;
   reg [10:0]  ratio_sel;
   reg [W-1:0] clamp;
   reg [W+10:0] low_prod;
   wire        cyc_done;
   wire        cmp_eq;
   wire        below_low;
   wire        above_low;
   wire        above_high;
   // Words are quasi-static levels; a torn sample heals next clock
   wire [W-1:0] init_s  = aw_r[W-1:0];
   wire [W-1:0] sunk_s  = aw_r[2*W-1:W];
   wire [2:0]   ratio_s = aw_r[2*W+2:2*W];

   // Two-flop synchronisers for all async inputs
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         fb1_r   <= {W{1'b0}};
         fb_r    <= {W{1'b0}};
         ss1_r   <= {W{1'b0}};
         ss_r    <= {W{1'b0}};
         aw1_r   <= {(2*W+3){1'b0}};
         aw_r    <= {(2*W+3){1'b0}};
         cyc_q_r <= 1'b0;
      end else begin
         sync1_r <= {sense_at_common_pin, cycle_done_pin, 1'b0};
         sync2_r <= sync1_r;
         fb1_r   <= feedback_replica;
         fb_r    <= fb1_r;
         ss1_r   <= softstart_level;
         ss_r    <= ss1_r;
         aw1_r   <= {ratio_option, sunk_mirror_level, init_mirror_level};
         aw_r    <= aw1_r;
         cyc_q_r <= sync2_r[1];
      end
   end

   // One pulse per completed switching cycle
   assign cyc_done   = sync2_r[1] & ~cyc_q_r;
   assign cmp_eq     = sync2_r[2];
   assign below_low  = fb_r < burst_low_threshold;
   assign above_low  = fb_r > burst_low_threshold;
   assign above_high = fb_r > burst_high_threshold;

   // Ratio option table; unknown codes fall back to ratio 1
   always @* begin
      case (ratio_s)
         3'd1:    ratio_sel = `BMSC_RATIO_OPT1;
         3'd2:    ratio_sel = `BMSC_RATIO_OPT2;
         3'd3:    ratio_sel = `BMSC_RATIO_OPT3;
         3'd4:    ratio_sel = `BMSC_RATIO_OPT4;
         3'd5:    ratio_sel = `BMSC_RATIO_OPT5;
         3'd6:    ratio_sel = `BMSC_RATIO_MIN;
         3'd7:    ratio_sel = `BMSC_RATIO_OPT7;
         default: ratio_sel = `BMSC_RATIO_OPT2;
      endcase
      low_prod = burst_high_threshold * ratio_r;
      clamp = (fb_r > burst_low_threshold) ? fb_r : burst_low_threshold;
   end

   // Five phase pin programming sequence
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_phase           <= `BMSC_PH_IDLE;
         softstart_initial    <= {W{1'b0}};
         ratio_r              <= `BMSC_RATIO_OPT2;
         burst_disabled       <= 1'b0;
         burst_high_threshold <= {W{1'b0}};
         burst_low_threshold  <= {W{1'b0}};
      end else begin
         // Low threshold always follows the high by the ratio
         burst_low_threshold <= low_prod[W+9:10];
         case (prog_phase)
            `BMSC_PH_IDLE: begin
               if (prog_start) begin
                  prog_phase <= `BMSC_PH_INIT;
               end
            end
            `BMSC_PH_INIT: begin
               softstart_initial <= init_s;
               ratio_r           <= ratio_sel;
               burst_disabled    <= (ratio_s == 3'd7);
               prog_phase        <= `BMSC_PH_PRECHG;
            end
            `BMSC_PH_PRECHG: begin
               if (!boot_charging) begin
                  prog_phase <= `BMSC_PH_SOFTSTART;
               end
            end
            `BMSC_PH_SOFTSTART: begin
               if (fb_r < ss_r) begin
                  prog_phase <= `BMSC_PH_LOWSETTLE;
               end
            end
            `BMSC_PH_LOWSETTLE: begin
               burst_high_threshold <= SETTLE_MV[W-1:0];
               prog_phase           <= `BMSC_PH_THRPROG;
            end
            `BMSC_PH_THRPROG: begin
               // Ramp one code per clock toward the sunk current value
               if (burst_high_threshold < sunk_s) begin
                  burst_high_threshold <= burst_high_threshold + 1'b1;
               end else if (burst_high_threshold > sunk_s) begin
                  burst_high_threshold <= burst_high_threshold - 1'b1;
               end else begin
                  prog_phase <= `BMSC_PH_DONE;
               end
            end
            `BMSC_PH_DONE: begin
               if (prog_start) begin
                  prog_phase <= `BMSC_PH_INIT;
               end
            end
            default: prog_phase <= `BMSC_PH_IDLE;
         endcase
      end
   end

   // Pin drive levels per phase
   always @* begin
      pin_hold_mv       = 13'h0;
      pin_bias_na       = 13'h0;
      winding_source_na = 16'h0;
      pin_drive_initial = 1'b0;
      softstart_charge  = 1'b0;
      case (prog_phase)
         `BMSC_PH_INIT: begin
            pin_hold_mv       = `BMSC_PIN_INIT_MV;
            pin_bias_na       = `BMSC_INIT_BIAS_NA;
            winding_source_na = `BMSC_BW_SOURCE_NA;
         end
         `BMSC_PH_PRECHG:    pin_drive_initial = 1'b1;
         `BMSC_PH_SOFTSTART: softstart_charge  = 1'b1;
         `BMSC_PH_THRPROG:   pin_hold_mv = `BMSC_PIN_THR_MV;
         default:            pin_hold_mv = 13'h0;
      endcase
   end

   // Burst state transitions
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_RUN: begin
            if (run_enable && below_low && !burst_disabled) begin
               st_nxt = ST_OFF;
            end
         end
         ST_OFF: begin
            if (above_high) begin
               st_nxt = ST_ON;
            end
         end
         ST_ON: begin
            if (cyc_done && soft_off_r && step_r == 3'd1 &&
                !above_low) begin
               st_nxt = ST_OFF;
            end
         end
         default: st_nxt = ST_RUN;
      endcase
      if (!run_enable) begin
         st_nxt = ST_RUN;
      end
   end

   // Packet counting and soft step sequencing
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r       <= ST_RUN;
         burst_mode <= 1'b0;
         pulse_r    <= 6'h0;
         step_r     <= 3'h0;
         soft_off_r <= 1'b0;
         soft_on_r  <= 1'b0;
         first_on_r <= 1'b0;
         above_high_q_r <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         above_high_q_r <= above_high;
         if (st_r == ST_RUN && st_nxt == ST_OFF) begin
            burst_mode <= 1'b1;
            first_on_r <= 1'b1;
         end else if (st_nxt == ST_RUN) begin
            burst_mode <= 1'b0;
            // A dropped ramp must not keep scaling the run effort
            soft_off_r <= 1'b0;
            soft_on_r  <= 1'b0;
            step_r     <= 3'd0;
         end
         if (st_r == ST_OFF && st_nxt == ST_ON) begin
            pulse_r    <= 6'h0;
            soft_off_r <= 1'b0;
            // First packet runs full effort; others ramp up
            soft_on_r  <= !first_on_r;
            step_r     <= first_on_r ? 3'd0 : 3'd1;
            first_on_r <= 1'b0;
         end else if (st_r == ST_ON && st_nxt == ST_OFF) begin
            soft_off_r <= 1'b0;
            step_r     <= 3'd0;
         end else if (st_r == ST_ON && st_nxt == ST_ON) begin
            // Restart itself is above high, so only a fresh rise cancels
            if (soft_on_r && above_high && !above_high_q_r) begin
               soft_on_r <= 1'b0;
               step_r    <= 3'd0;
            end else if (soft_off_r && above_low) begin
               soft_off_r <= 1'b0;
               soft_on_r  <= 1'b1;
               pulse_r    <= 6'h0;
            end else if (cyc_done) begin
               if (pulse_r != 6'h3f) begin
                  pulse_r <= pulse_r + 6'd1;
               end
               if (soft_on_r) begin
                  if (step_r == `BMSC_SOFT_STEPS) begin
                     soft_on_r <= 1'b0;
                     step_r    <= 3'd0;
                  end else begin
                     step_r <= step_r + 3'd1;
                  end
               end else if (soft_off_r) begin
                  step_r <= step_r - 3'd1;
               end else if (pulse_r >= `BMSC_PACKET_PULSES - 6'd1 -
                            {3'h0, `BMSC_SOFT_STEPS} && below_low) begin
                  soft_off_r <= 1'b1;
                  step_r     <= `BMSC_SOFT_STEPS;
               end
            end
         end
      end
   end

   // Effort scaling; clamp applies in and out of burst
   bmsc_scale #(
      .W(W)
   ) u_scale (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .effort_in  (clamp),
      .step_idx   (step_r),
      .effort_out (control_effort)
   );

   // Outputs
   assign switching_en   = run_enable && st_r != ST_OFF;
   assign power_down_req = st_r == ST_OFF;
   // Final pulse ends at sense node equal to common mode
   assign last_pulse_end = soft_off_r && step_r == 3'd1 &&
                           cmp_eq;
endmodule

// [rtl/bmsc_regs.vh]
`ifndef BMSC_REGS_VH
`define BMSC_REGS_VH
// Packet and soft step figures
`define BMSC_PACKET_PULSES   6'd40
`define BMSC_SOFT_STEPS      3'd7
// Ratio numerators over 1024
`define BMSC_RATIO_OPT1      11'd973
`define BMSC_RATIO_OPT2      11'd1024
`define BMSC_RATIO_OPT3      11'd922
`define BMSC_RATIO_OPT4      11'd819
`define BMSC_RATIO_OPT5      11'd614
`define BMSC_RATIO_MIN       11'd410
`define BMSC_RATIO_OPT7      11'd1024
// Pin programming levels, millivolts and nanoamps
`define BMSC_PIN_INIT_MV     13'd5000
`define BMSC_PIN_THR_MV      13'd3500
`define BMSC_HIGH_SETTLE_MV  13'd600
`define BMSC_INIT_BIAS_NA    13'd4000
`define BMSC_BW_SOURCE_NA    16'd54000
// Programming phase codes
`define BMSC_PH_IDLE         3'd0
`define BMSC_PH_INIT         3'd1
`define BMSC_PH_PRECHG       3'd2
`define BMSC_PH_SOFTSTART    3'd3
`define BMSC_PH_LOWSETTLE    3'd4
`define BMSC_PH_THRPROG      3'd5
`define BMSC_PH_DONE         3'd6
`endif

// [rtl/bmsc_scale.v]
`timescale 1ns/1ps
// Soft step scaling of the control effort, registered
module bmsc_scale #(
   parameter W = 12
) (
   // Clock and reset
   input  wire         core_clk,
   input  wire         rst_b,
   // Operand
   input  wire [W-1:0] effort_in,
   input  wire [2:0]   step_idx,
   // Result
   output reg  [W-1:0] effort_out
);
   reg [4:0]   num;
   reg [4:0]   den_sel;
   reg [W+4:0] prod;
   reg [W-1:0] res;
   reg [W+4:0] quo;

   // Step 0 means unscaled; fractions over 21, step 1 is 7/21
   always @* begin
      den_sel = 5'h15;
      case (step_idx)
         3'd1:    num = 5'h07;
         3'd2:    num = 5'h09;
         3'd3:    num = 5'h0b;
         3'd4:    num = 5'h0d;
         3'd5:    num = 5'h0f;
         3'd6:    num = 5'h11;
         3'd7:    num = 5'h13;
         default: num = 5'h15;
      endcase
      prod = effort_in * num;
      // Quotient never exceeds the operand, so the top bits drop safely
      quo  = prod / {{W{1'b0}}, den_sel};
      res  = quo[W-1:0];
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         effort_out <= {W{1'b0}};
      end else begin
         effort_out <= res;
      end
   end
endmodule

// [bench/bmsc_burst_sva.sv]
`timescale 1ns/1ps
// Port level checks on the burst sequencer
module bmsc_burst_sva #(
   parameter W = 12
) (
   // Clock and reset
   input wire         core_clk,
   input wire         rst_b,
   // Watched ports
   input wire         run_enable,
   input wire [W-1:0] feedback_replica,
   input wire         switching_en,
   input wire         last_pulse_end,
   input wire         burst_mode,
   input wire         power_down_req,
   input wire [W-1:0] burst_high_threshold,
   input wire [12:0]  pin_hold_mv,
   input wire [12:0]  pin_bias_na,
   input wire [15:0]  winding_source_na,
   input wire         pin_drive_initial,
   input wire         softstart_charge,
   input wire [2:0]   prog_phase,
   input wire         burst_disabled
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Burst-off is the only halt while running
   pd_pair_a:
   assert property (run_enable |-> switching_en != power_down_req)
      else $error("power down and switching disagree");
   entry_halt_a:
   assert property ($rose(burst_mode) |-> !switching_en)
      else $error("burst entry kept switching");
   // Sync delay plus one state cycle must fit in the window
   exit_bound_a:
   assert property ((power_down_req &&
      feedback_replica > burst_high_threshold) [*4] |=> !power_down_req)
      else $error("burst-off outlived high threshold");
   no_entry_a:
   assert property (burst_disabled && $past(burst_disabled)
      |-> !$rose(burst_mode))
      else $error("burst entered while disabled");
   last_pulse_a:
   assert property (last_pulse_end |-> switching_en && burst_mode)
      else $error("last pulse end outside burst-on");
   phase_order_a:
   assert property ($changed(prog_phase) && $past(prog_phase) != 3'h0 &&
      $past(prog_phase) != 3'h6 |-> prog_phase == $past(prog_phase) + 3'h1)
      else $error("programming phase out of order");
   init_short_a:
   assert property (prog_phase == 3'h1 |=> prog_phase != 3'h1)
      else $error("initial phase too long");
   init_levels_a:
   assert property (prog_phase == 3'h1 |-> pin_hold_mv == 13'h1388 &&
      pin_bias_na == 13'h0fa0 && winding_source_na == 16'hd2f0)
      else $error("initial phase pin levels wrong");
   thr_hold_a:
   assert property (prog_phase == 3'h5 |-> pin_hold_mv == 13'h0dac)
      else $error("threshold phase pin hold wrong");
   pre_drive_a:
   assert property (prog_phase == 3'h2 |-> pin_drive_initial)
      else $error("pre-charge not driving stored level");
   ss_charge_a:
   assert property (prog_phase == 3'h3 |-> softstart_charge)
      else $error("soft start not charging");
endmodule

bind bmsc_burst_ctrl bmsc_burst_sva #(.W(W)) i_bmsc_burst_sva (
   .core_clk(core_clk), .rst_b(rst_b), .run_enable(run_enable),
   .feedback_replica(feedback_replica), .switching_en(switching_en),
   .last_pulse_end(last_pulse_end), .burst_mode(burst_mode),
   .power_down_req(power_down_req),
   .burst_high_threshold(burst_high_threshold),
   .pin_hold_mv(pin_hold_mv), .pin_bias_na(pin_bias_na),
   .winding_source_na(winding_source_na),
   .pin_drive_initial(pin_drive_initial),
   .softstart_charge(softstart_charge), .prog_phase(prog_phase),
   .burst_disabled(burst_disabled));

// [bench/bmsc_stage_model.sv]
`timescale 1ns/1ps
// Power stage stand-in: one switching cycle each 2*HALF clocks
module bmsc_stage_model #(
   parameter HALF = 10
) (
   // Clock and reset
   input  wire core_clk,
   input  wire rst_b,
   // Gate enable from the sequencer
   input  wire switching_en,
   // Comparator outputs
   output reg  cycle_done_pin,
   output reg  sense_at_common_pin
);
   reg [7:0] ph_r;
   // Halted bridge stops dead, so no stray cycle ends appear
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b || !switching_en) begin
         ph_r <= 8'h00;
         cycle_done_pin <= 1'b0;
         sense_at_common_pin <= 1'b0;
      end else begin
         ph_r <= (ph_r == 2 * HALF - 1) ? 8'h00 : ph_r + 8'h01;
         cycle_done_pin <= (ph_r >= HALF - 1);
         sense_at_common_pin <= (ph_r >= HALF - 1);
      end
   end
endmodule

// [bench/burst_mode_softstep_control_test.sv]
`timescale 1ns/1ps
// Self-checking bench for the burst sequencer
module burst_mode_softstep_control_test;
   reg         core_clk, rst_b, prog_start, boot_charging, run_enable;
   reg  [11:0] feedback_replica, init_mirror_level;
   reg  [11:0] sunk_mirror_level, softstart_level;
   reg  [2:0]  ratio_option;
   wire        switching_en, burst_mode, burst_disabled;
   wire        cycle_done_pin, sense_at_common_pin;
   wire [11:0] control_effort, burst_low_threshold, burst_high_threshold;
   wire [11:0] softstart_initial;
   wire [2:0]  prog_phase;
   integer     errors, tests_run, cyc, o;
   reg  [31:0] seed;
   reg  [11:0] rv;
   reg  [2:0]  sel_q[$];
   reg  [15:0] exp_q[$];

   bmsc_burst_ctrl #(.W(12)) i_bmsc_burst_ctrl (
      .core_clk(core_clk), .rst_b(rst_b), .prog_start(prog_start),
      .boot_charging(boot_charging), .run_enable(run_enable),
      .cycle_done_pin(cycle_done_pin),
      .sense_at_common_pin(sense_at_common_pin),
      .feedback_replica(feedback_replica),
      .init_mirror_level(init_mirror_level),
      .sunk_mirror_level(sunk_mirror_level),
      .softstart_level(softstart_level), .ratio_option(ratio_option),
      .switching_en(switching_en), .last_pulse_end(),
      .control_effort(control_effort), .burst_mode(burst_mode),
      .power_down_req(), .burst_low_threshold(burst_low_threshold),
      .burst_high_threshold(burst_high_threshold),
      .softstart_initial(softstart_initial), .pin_hold_mv(),
      .pin_bias_na(), .winding_source_na(), .pin_drive_initial(),
      .softstart_charge(), .prog_phase(prog_phase),
      .burst_disabled(burst_disabled));

   bmsc_stage_model #(.HALF(10)) i_bmsc_stage_model (
      .core_clk(core_clk), .rst_b(rst_b), .switching_en(switching_en),
      .cycle_done_pin(cycle_done_pin),
      .sense_at_common_pin(sense_at_common_pin));

   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Ratio numerators over 1024, with high threshold at 1024
   function [15:0] rat(input [2:0] p);
      case (p)
         3'h1: rat = 16'h03cd;
         3'h3: rat = 16'h039a;
         3'h4: rat = 16'h0333;
         3'h5: rat = 16'h0266;
         3'h6: rat = 16'h019a;
         default: rat = 16'h0400;
      endcase
   endfunction

   function [15:0] obs(input [2:0] s);
      case (s)
         3'h0: obs = {4'h0, control_effort};
         3'h1: obs = {4'h0, burst_low_threshold};
         3'h2: obs = {4'h0, burst_high_threshold};
         3'h3: obs = {4'h0, softstart_initial};
         3'h4: obs = {15'h0000, burst_disabled};
         3'h5: obs = {15'h0000, burst_mode};
         default: obs = {15'h0000, switching_en};
      endcase
   endfunction

   task chk(input [2:0] s, input [15:0] v);
      sel_q.push_back(s);
      exp_q.push_back(v);
   endtask

   task conclude;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Every queued note, oldest first, against the settled output, mid cycle
   always @(negedge core_clk) begin
      while (exp_q.size() > 0) begin
         tests_run = tests_run + 1;
         if (obs(sel_q[0]) !== exp_q[0]) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp_q[0],
               obs(sel_q[0]));
         end
         sel_q.pop_front();
         exp_q.pop_front();
      end
   end

   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         errors = errors + 1;
         conclude;
      end
   end

   // One full pin programming run with a given ratio option
   task prog(input [2:0] opt);
      reg [11:0] iv;
      begin
         seed = lfsr(seed);
         iv = {2'b01, seed[9:0]};
         @(posedge core_clk);
         ratio_option <= opt;
         init_mirror_level <= iv;
         boot_charging <= 1'b1;
         feedback_replica <= 12'hbb8;
         repeat (3) @(posedge core_clk);
         prog_start <= 1'b1;
         @(posedge core_clk);
         prog_start <= 1'b0;
         wait (prog_phase === 3'h2);
         @(posedge core_clk);
         boot_charging <= 1'b0;
         wait (prog_phase === 3'h3);
         @(posedge core_clk);
         feedback_replica <= 12'h064;
         wait (prog_phase === 3'h6);
         repeat (3) @(posedge core_clk);
         chk(3'h1, rat(opt));
         chk(3'h2, 16'h0400);
         chk(3'h3, {4'h0, iv});
         chk(3'h4, {15'h0000, opt == 3'h7});
      end
   endtask

   // Packet pulses a..b; low threshold 819 = 39 * 21 keeps steps exact
   task pk(input integer a, input integer b, input [15:0] full);
      integer n;
      for (n = a; n <= b; n = n + 1) begin
         @(posedge cycle_done_pin);
         repeat (8) @(posedge core_clk);
         if (n == 40)
            chk(3'h6, 16'h0000);
         else if (n > 32)
            chk(3'h0, 16'(39 * (2 * (40 - n) + 5)));
         else
            chk(3'h0, full);
      end
   endtask

   initial begin
      errors = 0;
      tests_run = 0;
      cyc = 0;
      seed = 32'd82605;
      rst_b = 1'b0;
      prog_start = 1'b0;
      boot_charging = 1'b0;
      run_enable = 1'b0;
      feedback_replica = 12'h000;
      init_mirror_level = 12'h000;
      sunk_mirror_level = 12'h400;
      softstart_level = 12'h7d0;
      ratio_option = 3'h1;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      for (o = 1; o <= 7; o = o + 1)
         prog(o[2:0]);
      // Option 7: replica far below low, still no burst
      run_enable <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk(3'h5, 16'h0000);
      chk(3'h0, 16'h0400);
      run_enable <= 1'b0;
      prog(3'h4);
      seed = lfsr(seed);
      rv = {2'b10, seed[9:0]};
      // Replica settles above low first, so enabling cannot enter burst
      feedback_replica <= rv;
      repeat (3) @(posedge core_clk);
      run_enable <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk(3'h0, {4'h0, rv});
      feedback_replica <= 12'h1f4;
      repeat (10) @(posedge core_clk);
      chk(3'h5, 16'h0001);
      chk(3'h6, 16'h0000);
      feedback_replica <= rv;
      repeat (10) @(posedge core_clk);
      chk(3'h6, 16'h0001);
      chk(3'h0, {4'h0, rv});
      feedback_replica <= 12'h1f4;
      pk(1, 40, 16'h0333);
      // Later packet ramps from step 1; a fresh rise above high cancels
      feedback_replica <= rv;
      repeat (12) @(posedge core_clk);
      chk(3'h0, 16'((rv * 7) / 21));
      feedback_replica <= 12'h387;
      repeat (8) @(posedge core_clk);
      feedback_replica <= rv;
      repeat (10) @(posedge core_clk);
      chk(3'h0, {4'h0, rv});
      feedback_replica <= 12'h1f4;
      // First pulse of this packet ended before the loop starts
      pk(2, 35, 16'h0333);
      // Abort soft-off at step 5 with replica 903 = 43 * 21
      feedback_replica <= 12'h387;
      repeat (8) @(posedge core_clk);
      chk(3'h0, 16'h0285);
      repeat (10) @(posedge cycle_done_pin);
      repeat (8) @(posedge core_clk);
      chk(3'h0, 16'h0387);
      chk(3'h6, 16'h0001);
      repeat (4) @(posedge core_clk);
      conclude;
   end
endmodule
